//--- include/bbc_pkg.sv
// Package of the bit, branch and call execution block: widths, field places, operation and state codes.
// Assumes the decoder ahead of the block has already sorted out which instruction of the group is presented.
package bbc_pkg;
    localparam int PC_W = 15;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BSEL_W = 3;
    localparam int LIT_W = 11;
    localparam int BRK_W = 9;
    localparam int CALLK_W = 11;
    localparam int LATCH_W = 8;
    localparam int LATCH_HI = 6;
    localparam int LATCH_LO = 3;
    localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

    typedef enum logic [2:0] {
        BBC_OP_BIT_CLEAR = 3'h0,
        BBC_OP_BIT_SET = 3'h1,
        BBC_OP_LIT_BRANCH = 3'h2,
        BBC_OP_ACC_BRANCH = 3'h3,
        BBC_OP_SKIP_CLEAR = 3'h4,
        BBC_OP_SKIP_SET = 3'h5,
        BBC_OP_CALL = 3'h6,
        BBC_OP_OTHER = 3'h7
    } bbc_op_t;

    typedef enum logic [1:0] {
        BBC_ST_FIRST = 2'b01,
        BBC_ST_SECOND = 2'b10
    } bbc_state_t;
endpackage

//--- include/bbc_bit_if.sv
// Interface between the execution block and its bit unit.
// Assumes both ends sit on the same clock; the carried signals are combinational.
`timescale 1ns/1ps
interface bbc_bit_if;
    import bbc_pkg::*;
    logic [DATA_W-1:0] operand;
    logic [BSEL_W-1:0] bit_sel;
    logic set_bit;
    logic [DATA_W-1:0] result;
    logic tested;
    modport user (output operand, output bit_sel, output set_bit, input result, input tested);
    modport unit (input operand, input bit_sel, input set_bit, output result, output tested);
endinterface

//--- rtl/bbc_bit_unit.sv
// Bit unit: writes one selected bit of a data byte and reads that bit back out.
// Assumes its operand and bit number come through the interface from the execution block.
`timescale 1ns/1ps
module bbc_bit_unit (
    bbc_bit_if.unit bu
);
    import bbc_pkg::*;

    // One lane per bit; only the selected lane is rewritten.
    for (genvar i = 0; i < DATA_W; i++) begin : g_lane
        assign bu.result[i] = (bu.bit_sel == BSEL_W'(i)) ? bu.set_bit : bu.operand[i];
    end

    assign bu.tested = bu.operand[bu.bit_sel];
endmodule

//--- rtl/bbc_exec.sv
// Execution block for bit clear/set, bit test and skip, relative branches and the absolute call.
// Assumes the decoder presents one instruction with the addressed register's contents in the same cycle,
// and that the program counter, data memory and return stack act on the pulses the block drives out.
//
// How it works
// [RULE_01] Bit clear zeroes selected bit only.
// [RULE_02] Bit set raises selected bit only.
// [RULE_03] Literal branch: PC plus one plus signed nine-bit offset.
// [RULE_04] Accumulator branch adds unsigned accumulator, two cycles.
// [RULE_05] Skip-if-clear skips next when bit zero.
// [RULE_06] Skip-if-clear runs next when bit one.
// [RULE_07] Skip-if-set skips next when bit one.
// [RULE_08] Skip-if-set runs next when bit zero.
// [RULE_09] Call pushes PC plus one to stack.
// [RULE_10] Call loads eleven-bit target and latch bits.
// [RULE_11] Call takes two cycles.
// [RULE_12] No instruction here touches status flags.
// [RULE_13] Bit ops and unskipped tests take one cycle.
`timescale 1ns/1ps
module bbc_exec (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire bbc_pkg::bbc_op_t instr_op_i,
    input wire logic [bbc_pkg::FADDR_W-1:0] file_addr_i,
    input wire logic [bbc_pkg::BSEL_W-1:0] bit_sel_i,
    input wire logic [bbc_pkg::LIT_W-1:0] literal_i,
    input wire logic [bbc_pkg::DATA_W-1:0] file_data_i,
    input wire logic [bbc_pkg::DATA_W-1:0] accum_i,
    input wire logic [bbc_pkg::PC_W-1:0] pc_i,
    input wire logic [bbc_pkg::LATCH_W-1:0] upper_address_latch_i,
    output logic ready_o,
    output logic mem_we_o,
    output logic [bbc_pkg::FADDR_W-1:0] mem_addr_o,
    output logic [bbc_pkg::DATA_W-1:0] mem_wdata_o,
    output logic pc_load_o,
    output logic [bbc_pkg::PC_W-1:0] pc_new_o,
    output logic push_o,
    output logic [bbc_pkg::PC_W-1:0] stack_top_entry_o,
    output logic discard_o,
    output logic status_we_o
);
    import bbc_pkg::*;

    typedef struct packed {
        bbc_state_t st;
        logic mem_we;
        logic [FADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic pc_load;
        logic [PC_W-1:0] pc_new;
        logic push;
        logic [PC_W-1:0] stack_top_entry;
        logic discard;
        logic status_we;
    } bbc_exec_state_t;

    // Reset image: idle and ready, every pulse low, every held value zero.
    localparam bbc_exec_state_t S_RST = '{
        st: BBC_ST_FIRST,
        mem_we: 1'b0,
        mem_addr: FADDR_RST,
        mem_wdata: DATA_RST,
        pc_load: 1'b0,
        pc_new: PC_RST,
        push: 1'b0,
        stack_top_entry: PC_RST,
        discard: 1'b0,
        status_we: 1'b0
    };

    bbc_exec_state_t s_q;
    bbc_exec_state_t s_d;
    bbc_bit_if bu ();
    logic take;
    logic [PC_W-1:0] pc_next;
    logic [PC_W-1:0] br_offset;

    // Decoded targets and the skip decision.
    logic [PC_W-1:0] acc_ext;
    logic [PC_W-1:0] lit_target;
    logic [PC_W-1:0] acc_target;
    logic [PC_W-1:0] call_target;
    logic skip_hit;

    bbc_bit_unit u_bit (
        .bu(bu.unit)
    );

    assign take = instr_valid_i && (s_q.st == BBC_ST_FIRST);

    assign pc_next = pc_i + PC_ONE;
    assign br_offset = {{(PC_W-BRK_W){literal_i[BRK_W-1]}}, literal_i[BRK_W-1:0]};
    assign bu.operand = file_data_i;
    assign bu.bit_sel = bit_sel_i;
    assign bu.set_bit = (instr_op_i == BBC_OP_BIT_SET);

    // Branch targets wrap at the counter width, as the counter itself does.
    assign acc_ext = PC_W'(accum_i);
    assign lit_target = pc_next + br_offset;
    assign acc_target = pc_next + acc_ext;
    // The call keeps the latch's four middle bits above the eleven-bit target.
    assign call_target = {upper_address_latch_i[LATCH_HI:LATCH_LO], literal_i[CALLK_W-1:0]};

    // A skip happens when the tested bit matches the skip sense of the test.
    assign skip_hit = (instr_op_i == BBC_OP_SKIP_SET) ? bu.tested : !bu.tested;

    always_comb begin
        s_d = s_q;
        // Pulses last one cycle unless an instruction raises them again.
        s_d.mem_we = 1'b0;
        s_d.pc_load = 1'b0;
        s_d.push = 1'b0;
        s_d.discard = 1'b0;

        // Status flags are never written by this group.
        s_d.status_we = 1'b0; // [RULE_12]
        s_d.st = BBC_ST_FIRST;
        // One-hot state: ready, or the refused second cycle.
        unique case (s_q.st)
            BBC_ST_FIRST: begin
                // Only the ready state takes a new instruction.
                if (take) begin
                    unique case (instr_op_i)
                        BBC_OP_BIT_CLEAR, BBC_OP_BIT_SET: begin
                            // Single-cycle write of the byte with one bit changed.
                            s_d.mem_we = 1'b1;
                            s_d.mem_addr = file_addr_i;
                            s_d.mem_wdata = bu.result; // [RULE_01] [RULE_02]
                            s_d.st = BBC_ST_FIRST; // [RULE_13]
                        end

                        BBC_OP_LIT_BRANCH: begin
                            // The offset is the sign-extended low nine literal bits.
                            s_d.pc_load = 1'b1;
                            s_d.pc_new = lit_target; // [RULE_03]
                            s_d.discard = 1'b1;
                            s_d.st = BBC_ST_SECOND; // [RULE_03]
                        end

                        BBC_OP_ACC_BRANCH: begin
                            // The accumulator counts as unsigned.
                            s_d.pc_load = 1'b1;
                            s_d.pc_new = acc_target; // [RULE_04]
                            s_d.discard = 1'b1;
                            s_d.st = BBC_ST_SECOND; // [RULE_04]
                        end

                        BBC_OP_SKIP_CLEAR: begin
                            if (skip_hit) begin
                                s_d.discard = 1'b1; // [RULE_05]
                                s_d.st = BBC_ST_SECOND; // [RULE_05]
                            end else begin
                                // A clear test on a set bit lets the next instruction run.
                                s_d.st = BBC_ST_FIRST; // [RULE_06]
                            end
                        end

                        BBC_OP_SKIP_SET: begin
                            if (skip_hit) begin
                                s_d.discard = 1'b1; // [RULE_07]
                                s_d.st = BBC_ST_SECOND; // [RULE_07]
                            end else begin
                                // A set test on a clear bit lets the next instruction run.
                                s_d.st = BBC_ST_FIRST; // [RULE_08]
                            end
                        end

                        BBC_OP_CALL: begin
                            // Return address push and new counter value load go out in the same cycle.
                            s_d.push = 1'b1;
                            s_d.stack_top_entry = pc_next; // [RULE_09]
                            s_d.pc_load = 1'b1;
                            s_d.pc_new = call_target; // [RULE_10]
                            s_d.discard = 1'b1;
                            s_d.st = BBC_ST_SECOND; // [RULE_11]
                        end

                        BBC_OP_OTHER: begin
                            // Instructions outside the group pass through untouched.
                            s_d.st = BBC_ST_FIRST;
                        end
                    endcase
                end
            end

            BBC_ST_SECOND: begin
                // The refused cycle: any request is ignored while the fetched slot drains.
                s_d.st = BBC_ST_FIRST;
            end

            default: begin
                // An illegal state code falls back to the ready state.
                s_d.st = BBC_ST_FIRST;
            end
        endcase
    end

    // An unskipped test leaves the pipeline alone, so the next instruction runs. [RULE_06] [RULE_08]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Reset loads only constants.
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end


    // Every output but ready is read straight from a state register field.
    // Ready drops for the one refused cycle of a two-cycle instruction.
    assign ready_o = (s_q.st == BBC_ST_FIRST);
    assign mem_we_o = s_q.mem_we;
    assign mem_addr_o = s_q.mem_addr;
    assign mem_wdata_o = s_q.mem_wdata;
    assign pc_load_o = s_q.pc_load;
    assign pc_new_o = s_q.pc_new;
    assign push_o = s_q.push;
    assign stack_top_entry_o = s_q.stack_top_entry;
    assign discard_o = s_q.discard;
    assign status_we_o = s_q.status_we;
endmodule

//--- tb/bbc_mem_model.sv
// Data memory model: 128 bytes read in the same cycle, written on the write pulse.
// Assumes the bench presets a byte directly before an instruction reads it.
`timescale 1ns/1ps
module bbc_mem_model (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [128];
    assign rdata_o = mem[raddr_i];
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule

//--- tb/bbc_exec_checker.sv
// Checker of the execution block: each pulse and value against the instruction taken one edge before.
// Assumes it is bound to the execution block and sees its ports only.
`timescale 1ns/1ps
module bbc_exec_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire bbc_pkg::bbc_op_t instr_op_i,
    input wire logic [6:0] file_addr_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [10:0] literal_i,
    input wire logic [7:0] file_data_i,
    input wire logic [7:0] accum_i,
    input wire logic [14:0] pc_i,
    input wire logic [7:0] upper_address_latch_i,
    input wire logic ready_o,
    input wire logic mem_we_o,
    input wire logic [6:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic pc_load_o,
    input wire logic [14:0] pc_new_o,
    input wire logic push_o,
    input wire logic [14:0] stack_top_entry_o,
    input wire logic discard_o,
    input wire logic status_we_o
);
    import bbc_pkg::*;
    logic tk, bt;
    logic [7:0] clr_x, set_x;
    logic [14:0] ret_x, lit_x, acc_x, call_x;
    assign tk = instr_valid_i && ready_o;
    assign bt = file_data_i[bit_sel_i];
    assign clr_x = file_data_i & ~(8'h01 << bit_sel_i);
    assign set_x = file_data_i | (8'h01 << bit_sel_i);
    assign ret_x = pc_i + PC_ONE;
    assign lit_x = ret_x + {{6{literal_i[8]}}, literal_i[8:0]};
    assign acc_x = ret_x + {7'h00, accum_i};
    assign call_x = {upper_address_latch_i[6:3], literal_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_clear_bit: assert property (tk && instr_op_i == BBC_OP_BIT_CLEAR |=> mem_we_o && mem_wdata_o == $past(clr_x)
        && mem_addr_o == $past(file_addr_i)) else $error("clear");
    a_set_bit: assert property (tk && instr_op_i == BBC_OP_BIT_SET |=> mem_we_o && mem_wdata_o == $past(set_x)
        && mem_addr_o == $past(file_addr_i)) else $error("set");
    a_lit_branch: assert property (tk && instr_op_i == BBC_OP_LIT_BRANCH |=> pc_load_o && pc_new_o == $past(lit_x))
        else $error("lit");
    a_acc_branch: assert property (tk && instr_op_i == BBC_OP_ACC_BRANCH |=> pc_load_o && !ready_o
        && pc_new_o == $past(acc_x)) else $error("acc");
    a_skip_taken: assert property (tk && instr_op_i inside {BBC_OP_SKIP_CLEAR, BBC_OP_SKIP_SET}
        && (instr_op_i == BBC_OP_SKIP_CLEAR) != bt |=> discard_o && !pc_load_o && !ready_o) else $error("skip");
    a_no_skip: assert property (tk && (instr_op_i inside {BBC_OP_BIT_CLEAR, BBC_OP_BIT_SET}
        || instr_op_i inside {BBC_OP_SKIP_CLEAR, BBC_OP_SKIP_SET} && (instr_op_i == BBC_OP_SKIP_CLEAR) == bt)
        |=> ready_o && !discard_o) else $error("noskip");
    a_call_push: assert property (tk && instr_op_i == BBC_OP_CALL |=> push_o && stack_top_entry_o == $past(ret_x))
        else $error("push");
    a_call_target: assert property (tk && instr_op_i == BBC_OP_CALL |=> pc_new_o == $past(call_x) && !ready_o ##1 ready_o)
        else $error("call");
    a_status_quiet: assert property (!status_we_o) else $error("status");
    c_call: cover property (tk && instr_op_i == BBC_OP_CALL);
    c_skip: cover property (tk && instr_op_i == BBC_OP_SKIP_SET && bt);
    c_refused: cover property (instr_valid_i && !ready_o);
endmodule
bind bbc_exec bbc_exec_checker bbc_exec_checker_inst (.*);

//--- tb/bbc_exec_tb_top.sv
// Bench of the execution block: a table of instructions, then a refused request and a write-back case.
// Assumes the data memory model answers reads in the same cycle.
`timescale 1ns/1ps
module bbc_exec_tb_top;
    import bbc_pkg::*;
    `define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
    typedef struct packed {logic [2:0] op; logic [2:0] sel; logic [7:0] data; logic [10:0] lit; logic [14:0] pc; logic [14:0] ex; logic disc;} bbc_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, ld;
    bbc_op_t instr_op_i = BBC_OP_OTHER;
    logic [6:0] file_addr_i = 7'h00, mem_addr_o;
    logic [2:0] bit_sel_i = 3'h0;
    logic [10:0] literal_i = 11'h000;
    logic [7:0] file_data_i, mem_wdata_o, accum_i = 8'hF0, upper_address_latch_i = 8'h28;
    logic [14:0] pc_i = 15'h0000, pc_new_o, stack_top_entry_o;
    logic ready_o, mem_we_o, pc_load_o, push_o, discard_o, status_we_o;
    int num_errors = 0, checks = 0;
    bbc_row_t r;
    bbc_row_t rows [10] = '{'{3'h0, 3'h3, 8'hFF, 11'h000, 15'h0000, 15'h00F7, 1'b0}, '{3'h1, 3'h7, 8'h00, 11'h000, 15'h0000, 15'h0080, 1'b0},
        '{3'h2, 3'h0, 8'h00, 11'h100, 15'h0100, 15'h0001, 1'b1}, '{3'h3, 3'h0, 8'h00, 11'h000, 15'h7FFF, 15'h00F0, 1'b1},
        '{3'h4, 3'h0, 8'hFE, 11'h000, 15'h0000, 15'h0000, 1'b1}, '{3'h4, 3'h0, 8'h01, 11'h000, 15'h0000, 15'h0000, 1'b0},
        '{3'h5, 3'h7, 8'h80, 11'h000, 15'h0000, 15'h0000, 1'b1}, '{3'h5, 3'h7, 8'h7F, 11'h000, 15'h0000, 15'h0000, 1'b0},
        '{3'h6, 3'h0, 8'h00, 11'h123, 15'h0010, 15'h2923, 1'b1}, '{3'h6, 3'h0, 8'h00, 11'h7FF, 15'h7FFF, 15'h2FFF, 1'b1}};
    bbc_exec bbc_exec_inst (.*);
    bbc_mem_model bbc_mem_model_inst (.clk_i, .we_i(mem_we_o), .waddr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .raddr_i(file_addr_i), .rdata_o(file_data_i));
    always #4 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #2000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        `CHK("rst_ready", 1'b1, ready_o)
        `CHK("rst_pc", 15'h0000, pc_new_o)
        foreach (rows[i]) begin
            r = rows[i];
            @(negedge clk_i);
            bbc_mem_model_inst.mem[i] = r.data;
            instr_valid_i = 1'b1;
            instr_op_i = bbc_op_t'(r.op);
            file_addr_i = 7'(i);
            bit_sel_i = r.sel;
            literal_i = r.lit;
            pc_i = r.pc;
            @(negedge clk_i);
            instr_valid_i = 1'b0;
            ld = r.op inside {3'h2, 3'h3, 3'h6};
            `CHK("ready", ~r.disc, ready_o)
            `CHK("discard", r.disc, discard_o)
            `CHK("write", r.op < 3'h2, mem_we_o)
            if (r.op < 3'h2) `CHK("wdata", r.ex[7:0], mem_wdata_o)
            if (r.op < 3'h2) `CHK("waddr", 7'(i), mem_addr_o)
            `CHK("load", ld, pc_load_o)
            if (ld) `CHK("pc", r.ex, pc_new_o)
            `CHK("push", r.op == 3'h6, push_o)
            if (r.op == 3'h6) `CHK("ret", r.pc + 15'h0001, stack_top_entry_o)
            `CHK("status", 1'b0, status_we_o)
        end
        // A request held while the block is busy is taken one edge late; the set bit is then read back.
        @(negedge clk_i);
        bbc_mem_model_inst.mem[10] = 8'h00;
        instr_valid_i = 1'b1;
        instr_op_i = BBC_OP_CALL;
        @(negedge clk_i);
        instr_op_i = BBC_OP_BIT_SET;
        file_addr_i = 7'h0A;
        `CHK("busy", 1'b0, ready_o)
        @(negedge clk_i);
        `CHK("refused", 1'b0, mem_we_o)
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        `CHK("late_set", 8'h01, mem_wdata_o)
        @(negedge clk_i);
        instr_valid_i = 1'b1;
        instr_op_i = BBC_OP_SKIP_SET;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        `CHK("readback", 1'b1, discard_o)
        // Reset in the middle of a call drops every pulse and restores readiness at once.
        @(negedge clk_i);
        instr_valid_i = 1'b1;
        instr_op_i = BBC_OP_CALL;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        rst_i = 1'b1;
        #1;
        `CHK("mid_rst_ready", 1'b1, ready_o)
        `CHK("mid_rst_push", 1'b0, push_o)
        @(negedge clk_i);
        rst_i = 1'b0;
        `CHK("mid_rst_pc", 15'h0000, pc_new_o)
        report_and_stop();
    end
endmodule
